// ===== rtl/asw_conv_timer.sv
// Conversion timer: sampling phase plus the fixed conversion cycles.
// Assumes tick is a one-cycle converter clock enable on pclk.
module asw_conv_timer
   import asw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic launch,
   input wire logic abort,
   input wire logic [4:0] channel_in,
   input wire logic [8:0] sample_cycles,
   output logic busy,
   output logic sampling,
   output logic done,
   output logic [4:0] channel
);

   logic [9:0] cnt_q;
   logic busy_q;
   logic [4:0] ch_q;

   assign busy = busy_q;
   assign channel = ch_q;
   assign sampling = busy_q & (cnt_q > CONV_FIXED_CYC);
   assign done = busy_q & tick & (cnt_q == 10'h001);

   // Abort wins so an injected request can cut a regular conversion.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q <= 10'h000;
         ch_q <= 5'h00;
      end else if (abort) begin
         busy_q <= 1'b0;
      end else if (launch) begin
         busy_q <= 1'b1;
         cnt_q <= {1'b0, sample_cycles} + CONV_FIXED_CYC; // RULE23
         ch_q <= channel_in;
      end else if (busy_q & tick) begin
         cnt_q <= cnt_q - 10'h001;
         if (cnt_q == 10'h001) begin
            busy_q <= 1'b0;
         end
      end
   end

endmodule : asw_conv_timer

// ===== rtl/asw_pkg.sv
// Register map, field positions, reset values and shared types of the
// converter sequencer. Assumes one pclk domain with the converter clock
// derived from it as an enable pulse.
package asw_pkg;

   // Converter clock is pclk divided by this figure plus one.
   localparam logic [3:0] CONV_DIV_LAST = 4'h1;
   localparam logic [9:0] CONV_FIXED_CYC = 10'h00C;
   localparam logic [4:0] LAST_CH = 5'h12;

   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL2 = 8'h08;
   localparam logic [7:0] OFS_SMP_HI = 8'h0C;
   localparam logic [7:0] OFS_SMP_LO = 8'h10;
   localparam logic [7:0] OFS_JOFF0 = 8'h14;
   localparam logic [7:0] OFS_HTR = 8'h24;
   localparam logic [7:0] OFS_LTR = 8'h28;
   localparam logic [7:0] OFS_SEQ0 = 8'h2C;
   localparam logic [7:0] OFS_JSEQ = 8'h38;
   localparam logic [7:0] OFS_JRES0 = 8'h3C;
   localparam logic [7:0] OFS_DR = 8'h4C;

   localparam int SR_WD = 0;
   localparam int SR_EOC = 1;
   localparam int SR_INJECTED_DONE_FLAG = 2;
   localparam int SR_BUSY = 3;

   localparam int CR1_WDCH = 0;
   localparam int CR1_IRQ = 6;
   localparam int CR1_SCAN = 8;
   localparam int CR1_SGL = 9;
   localparam int CR1_AUTO = 10;
   localparam int CR1_DISC = 11;
   localparam int CR1_JDISC = 12;
   localparam int CR1_DNUM = 13;
   localparam int CR1_JWD = 22;
   localparam int CR1_WD = 23;
   localparam int CR1_RES = 24;
   localparam logic [31:0] CR1_MASK = 32'h03C0_FF7F;

   localparam int CR2_ON = 0;
   localparam int CR2_CONTINUOUS_SEL = 1;
   localparam int CR2_DMA = 8;
   localparam int CR2_PER_CONVERSION_FLAG_SEL = 10;
   localparam int CR2_ALIGN = 11;
   localparam int CR2_JSW = 22;
   localparam int CR2_SW = 30;
   localparam logic [31:0] CR2_MASK = 32'h0000_0D03;

   localparam logic [31:0] SMP_HI_MASK = 32'h07FF_FFFF;
   localparam logic [31:0] SMP_LO_MASK = 32'h3FFF_FFFF;
   localparam logic [31:0] SEQ_TOP_MASK = 32'h00FF_FFFF;
   localparam logic [31:0] SEQ_MASK = 32'h3FFF_FFFF;
   localparam logic [31:0] JSEQ_MASK = 32'h003F_FFFF;
   localparam int SEQ_LEN = 20;
   localparam int JSEQ_LEN = 20;

   localparam logic [11:0] HTR_RESET = 12'hFFF;
   localparam logic [11:0] LTR_RESET = 12'h000;
   localparam logic [1:0] RES_6BIT = 2'h3;

   // Sampling cycles for each select code: a plain ladder of 3 + 4 * sel.
   function automatic logic [8:0] asw_smp_cycles(input logic [2:0] sel);
      return 9'h003 + {4'h0, sel, 2'b00};
   endfunction : asw_smp_cycles

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REG = 3'b010,
      ST_INJ = 3'b100
   } asw_state_t;

   typedef struct packed {
      logic left;
      logic [1:0] res;
      logic inj;
      logic [11:0] offset;
      logic single;
      logic wd_reg_en;
      logic wd_inj_en;
      logic [4:0] wd_ch;
      logic [11:0] high;
      logic [11:0] low;
   } asw_rp_cfg_t;

   typedef struct packed {
      logic [15:0] data;
      logic wd_hit;
   } asw_res_t;

endpackage : asw_pkg

// ===== rtl/asw_result_path.sv
// Watchdog compare and result formatting for one finished conversion.
// Purely combinational; the caller registers what it keeps.
module asw_result_path
   import asw_pkg::*;
(
   input wire asw_rp_cfg_t cfg,
   input wire logic [4:0] channel,
   input wire logic [11:0] raw,
   output asw_res_t res
);

   wire guard_grp = cfg.inj ? cfg.wd_inj_en : cfg.wd_reg_en;
   wire guard = guard_grp & (~cfg.single | (channel == cfg.wd_ch)); // RULE5
   // Compared on the raw code, so alignment never moves the window.
   wire outside = (raw < cfg.low) | (raw > cfg.high); // RULE1 RULE2 RULE3

   wire [11:0] scaled = raw >> {cfg.res, 1'b0};
   wire [12:0] diff = {1'b0, scaled} - {1'b0, cfg.offset};
   wire [15:0] sign_extension = {{3{diff[12]}}, diff}; // RULE21
   wire [15:0] plain = {4'h0, scaled}; // RULE21
   wire [15:0] right = cfg.inj ? sign_extension : plain;
   wire is6 = cfg.res == RES_6BIT;
   wire [3:0] sh_hw = 4'h4 + {1'b0, cfg.res, 1'b0} - {3'h0, cfg.inj};
   wire [3:0] sh_b = cfg.inj ? 4'h1 : 4'h2;
   wire [3:0] shamt = is6 ? sh_b : sh_hw;

   assign res.wd_hit = guard & outside;
   assign res.data = cfg.left ? (right << shamt) : right; // RULE22

endmodule : asw_result_path

// ===== rtl/asw_top.sv
// Converter sequencer: APB registers, group scanning, injection,
// discontinuous subgroups, watchdog, DMA request and result storage.
// Assumes the analog core returns core_result valid when a conversion
// ends; triggers arrive asynchronously and are synchronised here.
// Notes on behaviour
// RULE1: Watchdog flag sets when a guarded result is below low or above high.
// RULE2: Thresholds are the low twelve bits of sixteen-bit registers.
// RULE3: Watchdog compares the raw result, before alignment.
// RULE4: With its enable set, the watchdog flag raises the interrupt line.
// RULE5: Regular, injected and single-channel bits choose which channels are guarded.
// RULE6: Scan converts each programmed channel of the group once, in order.
// RULE7: Scan with continuous restarts the regular group at its first channel.
// RULE8: DMA mode requests a transfer after every regular conversion.
// RULE9: End flag per sequence, or per conversion when the select bit is one.
// RULE10: Injected results land in the result register of their rank.
// RULE11: Injected start during regular work aborts it and scans injected once.
// RULE12: Regular work resumes at the interrupted conversion afterwards.
// RULE13: Regular triggers during injected work wait until it completes.
// RULE14: Injected triggers must be spaced wider than the injected sequence.
// RULE15: Auto injection converts the injected group after the regular group.
// RULE16: Software disables injected triggering while auto injection is set.
// RULE17: Auto injection with continuous repeats both groups without triggers.
// RULE18: Software never mixes auto injection and discontinuous modes.
// RULE19: Regular discontinuous converts n channels per trigger, then wraps.
// RULE20: Injected discontinuous converts one channel per trigger, then wraps.
// RULE21: Injected results lose their offset and are sign extended.
// RULE22: Alignment bit picks right or left; six-bit left is byte based.
// RULE23: Conversion lasts the channel sampling cycles plus twelve.
// RULE24: Watchdog flag stays set until software clears it.
//
// Our own choices: the register offsets and register access over APB.
module asw_top
   import asw_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic regular_trigger,
   input wire logic injected_trigger,
   input wire logic [11:0] core_result,
   output logic [4:0] conv_channel,
   output logic conv_sampling,
   output logic conv_active,
   output logic dma_req,
   output logic watchdog_irq
);

   logic [31:0] control_one_q, control_two_q;
   logic [31:0] sample_time_reg_hi_q, sample_time_reg_lo_q;
   logic [11:0] injected_offset_regs_q [4];
   logic [11:0] high_threshold_q, low_threshold_q;
   logic [31:0] regular_sequence_regs_q [3];
   logic [31:0] injected_sequence_reg_q;
   logic [15:0] injected_result_regs_q [4];
   logic [15:0] regular_result_reg_q;
   logic watchdog_flag_q, eoc_q, injected_done_flag_q;
   logic watchdog_flag_d, eoc_d, injected_done_flag_d;
   logic [31:0] prdata_q, rd_mux, sr_word;
   logic [3:0] div_q;
   logic tick_q;
   logic [1:0] trg_meta_q, trg_sync_q, trg_prev_q;
   asw_state_t st_q, st_d;
   logic [3:0] reg_idx_q, reg_idx_d;
   logic [1:0] inj_idx_q, inj_idx_d;
   logic [2:0] sub_q, sub_d;
   logic reg_pend_q, reg_pend_d, ret_q, ret_d;
   logic abort, eoc_set, injected_done_flag_set, dr_we, jres_we;
   logic dma_req_q;
   logic tmr_busy, tmr_done;
   asw_rp_cfg_t rp_cfg;
   asw_res_t res;

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle.
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire [7:0] a = {paddr[7:2], 2'b00};
   wire hit_sr = a == OFS_STATUS;
   wire hit_cr1 = a == OFS_CTRL1;
   wire hit_cr2 = a == OFS_CTRL2;
   wire hit_smph = a == OFS_SMP_HI;
   wire hit_smpl = a == OFS_SMP_LO;
   wire hit_htr = a == OFS_HTR;
   wire hit_ltr = a == OFS_LTR;
   wire hit_jseq = a == OFS_JSEQ;
   wire hit_dr = a == OFS_DR;
   wire in_joff = (a >= OFS_JOFF0) & (a < OFS_HTR);
   wire in_seq = (a >= OFS_SEQ0) & (a < OFS_JSEQ);
   wire in_jres = (a >= OFS_JRES0) & (a < OFS_DR);
   wire [7:0] joff_rel = a - OFS_JOFF0;
   wire [7:0] seq_rel = a - OFS_SEQ0;
   wire [7:0] jres_rel = a - OFS_JRES0;
   wire [1:0] joff_idx = joff_rel[3:2];
   wire [1:0] seq_idx = seq_rel[3:2];
   wire [1:0] jres_idx = jres_rel[3:2];
   wire addr_ok = hit_sr | hit_cr1 | hit_cr2 | hit_smph | hit_smpl |
      hit_htr | hit_ltr | hit_jseq | hit_dr | in_joff | in_seq | in_jres;

   assign pready = 1'b1;
   assign pslverr = acc & ~addr_ok;
   assign prdata = prdata_q;

   always_comb begin
      sr_word = 32'h0000_0000;
      sr_word[SR_WD] = watchdog_flag_q;
      sr_word[SR_EOC] = eoc_q;
      sr_word[SR_INJECTED_DONE_FLAG] = injected_done_flag_q;
      sr_word[SR_BUSY] = conv_active;
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_sr) begin
         rd_mux = sr_word;
      end else if (hit_cr1) begin
         rd_mux = control_one_q;
      end else if (hit_cr2) begin
         rd_mux = control_two_q;
      end else if (hit_smph) begin
         rd_mux = sample_time_reg_hi_q;
      end else if (hit_smpl) begin
         rd_mux = sample_time_reg_lo_q;
      end else if (hit_htr) begin
         rd_mux = {20'h0_0000, high_threshold_q};
      end else if (hit_ltr) begin
         rd_mux = {20'h0_0000, low_threshold_q};
      end else if (hit_jseq) begin
         rd_mux = injected_sequence_reg_q;
      end else if (hit_dr) begin
         rd_mux = {16'h0000, regular_result_reg_q};
      end else if (in_joff) begin
         rd_mux = {20'h0_0000, injected_offset_regs_q[joff_idx]};
      end else if (in_seq) begin
         rd_mux = regular_sequence_regs_q[seq_idx];
      end else if (in_jres) begin
         rd_mux = {16'h0000, injected_result_regs_q[jres_idx]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers. Start bits are not stored; writing one is an event.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_one_q <= 32'h0000_0000;
         control_two_q <= 32'h0000_0000;
         sample_time_reg_hi_q <= 32'h0000_0000;
         sample_time_reg_lo_q <= 32'h0000_0000;
         high_threshold_q <= HTR_RESET;
         low_threshold_q <= LTR_RESET;
         injected_sequence_reg_q <= 32'h0000_0000;
      end else if (wr) begin
         if (hit_cr1) control_one_q <= pwdata & CR1_MASK;
         if (hit_cr2) control_two_q <= pwdata & CR2_MASK;
         if (hit_smph) sample_time_reg_hi_q <= pwdata & SMP_HI_MASK;
         if (hit_smpl) sample_time_reg_lo_q <= pwdata & SMP_LO_MASK;
         if (hit_htr) high_threshold_q <= pwdata[11:0]; // RULE2
         if (hit_ltr) low_threshold_q <= pwdata[11:0]; // RULE2
         if (hit_jseq) injected_sequence_reg_q <= pwdata & JSEQ_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            injected_offset_regs_q[i] <= 12'h000;
         end
         for (int i = 0; i < 3; i++) begin
            regular_sequence_regs_q[i] <= 32'h0000_0000;
         end
      end else if (wr) begin
         if (in_joff) injected_offset_regs_q[joff_idx] <= pwdata[11:0];
         if (in_seq) begin
            regular_sequence_regs_q[seq_idx] <= pwdata &
               ((seq_idx == 2'h0) ? SEQ_TOP_MASK : SEQ_MASK);
         end
      end
   end

   wire on = control_two_q[CR2_ON];
   wire continuous_sel = control_two_q[CR2_CONTINUOUS_SEL];
   wire dma_en = control_two_q[CR2_DMA];
   wire per_conv = control_two_q[CR2_PER_CONVERSION_FLAG_SEL];
   wire scan = control_one_q[CR1_SCAN];
   wire auto_inject_en = control_one_q[CR1_AUTO];
   wire regular_discont_en = control_one_q[CR1_DISC];
   wire injected_discont_en = control_one_q[CR1_JDISC];
   wire [2:0] discont_count = control_one_q[CR1_DNUM +: 3];
   wire soft_regular_start = wr & hit_cr2 & pwdata[CR2_SW];
   wire soft_injected_start = wr & hit_cr2 & pwdata[CR2_JSW];

   ////////////////////////////////////////////////////////////////////////
   // Converter clock enable and trigger pin synchronisers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 4'h0;
         tick_q <= 1'b0;
         trg_meta_q <= 2'b00;
         trg_sync_q <= 2'b00;
         trg_prev_q <= 2'b00;
      end else begin
         div_q <= (div_q == CONV_DIV_LAST) ? 4'h0 : div_q + 4'h1;
         tick_q <= div_q == CONV_DIV_LAST;
         trg_meta_q <= {injected_trigger, regular_trigger};
         trg_sync_q <= trg_meta_q;
         trg_prev_q <= trg_sync_q;
      end
   end

   wire [1:0] trg_rise = trg_sync_q & ~trg_prev_q;
   wire reg_ev = trg_rise[0] | soft_regular_start;
   wire inj_ev = trg_rise[1] | soft_injected_start;

   ////////////////////////////////////////////////////////////////////////
   // Channel lookup for the rank in progress.
   wire [79:0] seq_flat = {regular_sequence_regs_q[0][19:0],
      regular_sequence_regs_q[1][29:0], regular_sequence_regs_q[2][29:0]};
   wire [3:0] reg_len_m1 = regular_sequence_regs_q[0][SEQ_LEN +: 4];
   wire [1:0] injected_length = injected_sequence_reg_q[JSEQ_LEN +: 2];
   wire [6:0] reg_pos = {1'b0, reg_idx_q, 2'b00} + {3'h0, reg_idx_q};
   wire [4:0] inj_pos = {1'b0, inj_idx_q, 2'b00} + {3'h0, inj_idx_q};
   wire [4:0] reg_ch = seq_flat[reg_pos +: 5];
   wire [4:0] inj_ch = injected_sequence_reg_q[inj_pos +: 5];
   wire [4:0] cur_ch = (st_q == ST_INJ) ? inj_ch : reg_ch;
   wire [4:0] ch_cl = (cur_ch > LAST_CH) ? 5'h00 : cur_ch;
   wire [56:0] smp_flat = {sample_time_reg_hi_q[26:0],
      sample_time_reg_lo_q[29:0]};
   wire [5:0] smp_pos = {1'b0, ch_cl} + {ch_cl, 1'b0};
   wire [8:0] smp_cyc = asw_smp_cycles(smp_flat[smp_pos +: 3]); // RULE23
   wire launch = (st_q != ST_IDLE) & ~tmr_busy & ~abort;

   asw_conv_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_q),
      .launch(launch),
      .abort(abort),
      .channel_in(cur_ch),
      .sample_cycles(smp_cyc),
      .busy(tmr_busy),
      .sampling(conv_sampling),
      .done(tmr_done),
      .channel(conv_channel)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer.
   wire last_r = scan ? (reg_idx_q == reg_len_m1) : 1'b1;
   wire last_j = inj_idx_q == injected_length;

   always_comb begin
      st_d = st_q;
      reg_idx_d = reg_idx_q;
      inj_idx_d = inj_idx_q;
      sub_d = sub_q;
      reg_pend_d = reg_pend_q;
      ret_d = ret_q;
      abort = 1'b0;
      eoc_set = 1'b0;
      injected_done_flag_set = 1'b0;
      dr_we = 1'b0;
      jres_we = 1'b0;
      if (!on) begin
         st_d = ST_IDLE;
         abort = 1'b1;
         reg_pend_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (inj_ev) begin
                  st_d = ST_INJ;
                  ret_d = 1'b0;
               end else if (reg_ev | reg_pend_q) begin
                  st_d = ST_REG;
                  reg_pend_d = 1'b0;
               end
            end
            ST_REG: begin
               if (inj_ev & ~auto_inject_en) begin
                  // Rank index is left alone so the cut one reruns.
                  abort = 1'b1; // RULE11
                  st_d = ST_INJ; // RULE11
                  ret_d = 1'b1; // RULE12
               end else if (tmr_done) begin
                  dr_we = 1'b1;
                  if (regular_discont_en) begin
                     eoc_set = 1'b1; // RULE19
                     reg_idx_d = last_r ? 4'h0 : reg_idx_q + 4'h1; // RULE19
                     sub_d = sub_q + 3'h1;
                     if (last_r | (sub_q == discont_count)) begin
                        st_d = ST_IDLE; // RULE19
                        sub_d = 3'h0;
                     end
                  end else if (!last_r) begin
                     reg_idx_d = reg_idx_q + 4'h1; // RULE6
                     eoc_set = per_conv; // RULE9
                  end else begin
                     reg_idx_d = 4'h0;
                     eoc_set = 1'b1; // RULE9
                     if (auto_inject_en) begin
                        st_d = ST_INJ; // RULE15
                        ret_d = continuous_sel; // RULE17
                        inj_idx_d = 2'h0;
                     end else if (!continuous_sel) begin // RULE7
                        st_d = ST_IDLE;
                     end
                  end
               end
            end
            ST_INJ: begin
               if (reg_ev) reg_pend_d = 1'b1; // RULE13
               if (tmr_done) begin
                  jres_we = 1'b1;
                  if (injected_discont_en) begin
                     inj_idx_d = last_j ? 2'h0 : inj_idx_q + 2'h1; // RULE20
                     injected_done_flag_set = last_j; // RULE20
                     st_d = ret_q ? ST_REG : ST_IDLE;
                  end else if (!last_j) begin
                     inj_idx_d = inj_idx_q + 2'h1; // RULE11
                  end else begin
                     inj_idx_d = 2'h0;
                     injected_done_flag_set = 1'b1;
                     st_d = (ret_q | reg_pend_q | reg_ev) ? ST_REG : ST_IDLE;
                  end
                  if (st_d == ST_REG) reg_pend_d = 1'b0; // RULE12 RULE13
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         reg_idx_q <= 4'h0;
         inj_idx_q <= 2'h0;
         sub_q <= 3'h0;
         reg_pend_q <= 1'b0;
         ret_q <= 1'b0;
      end else begin
         st_q <= st_d;
         reg_idx_q <= reg_idx_d;
         inj_idx_q <= inj_idx_d;
         sub_q <= sub_d;
         reg_pend_q <= reg_pend_d;
         ret_q <= ret_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result formatting, watchdog and status flags.
   assign rp_cfg.left = control_two_q[CR2_ALIGN];
   assign rp_cfg.res = control_one_q[CR1_RES +: 2];
   assign rp_cfg.inj = st_q == ST_INJ;
   assign rp_cfg.offset = injected_offset_regs_q[inj_idx_q];
   assign rp_cfg.single = control_one_q[CR1_SGL];
   assign rp_cfg.wd_reg_en = control_one_q[CR1_WD];
   assign rp_cfg.wd_inj_en = control_one_q[CR1_JWD];
   assign rp_cfg.wd_ch = control_one_q[CR1_WDCH +: 5];
   assign rp_cfg.high = high_threshold_q;
   assign rp_cfg.low = low_threshold_q;

   asw_result_path u_result (
      .cfg(rp_cfg),
      .channel(conv_channel),
      .raw(core_result),
      .res(res)
   );

   // Status bits clear on a written zero; a same-cycle set wins.
   wire sr_wr = wr & hit_sr;
   wire wd_set = (dr_we | jres_we) & res.wd_hit; // RULE1
   assign watchdog_flag_d = wd_set |
      (watchdog_flag_q & ~(sr_wr & ~pwdata[SR_WD])); // RULE24
   assign eoc_d = eoc_set | (eoc_q & ~(sr_wr & ~pwdata[SR_EOC]));
   assign injected_done_flag_d = injected_done_flag_set |
      (injected_done_flag_q & ~(sr_wr & ~pwdata[SR_INJECTED_DONE_FLAG]));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_flag_q <= 1'b0;
         eoc_q <= 1'b0;
         injected_done_flag_q <= 1'b0;
         dma_req_q <= 1'b0;
         regular_result_reg_q <= 16'h0000;
         for (int i = 0; i < 4; i++) begin
            injected_result_regs_q[i] <= 16'h0000;
         end
      end else begin
         watchdog_flag_q <= watchdog_flag_d;
         eoc_q <= eoc_d;
         injected_done_flag_q <= injected_done_flag_d;
         dma_req_q <= dr_we & dma_en; // RULE8
         if (dr_we) regular_result_reg_q <= res.data;
         if (jres_we) injected_result_regs_q[inj_idx_q] <= res.data; // RULE10
      end
   end

   assign dma_req = dma_req_q;
   assign conv_active = tmr_busy;
   assign watchdog_irq = watchdog_flag_q & control_one_q[CR1_IRQ]; // RULE4

endmodule : asw_top

// ===== test/asw_core_model.sv
// Analog core model: answers each conversion with a code built from
// the channel number. Assumes conv_active marks a running conversion.
module asw_core_model (
   input wire logic pclk,
   input wire logic [4:0] conv_channel,
   input wire logic conv_active,
   output logic [11:0] core_result
);
   timeunit 1ns;
   timeprecision 1ps;
   initial core_result = 12'h000;
   // Between conversions the code toggles, so a stale sample cannot pass.
   always @(posedge pclk) begin
      core_result <= conv_active ? {conv_channel[3:0], 8'h50} : ~core_result;
   end
endmodule : asw_core_model

// ===== test/asw_top_props.sv
// Port checks of the converter sequencer.
// Assumes it is bound into asw_top; one pclk domain.
module asw_top_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic pwrite,
   input wire logic [4:0] conv_channel,
   input wire logic conv_sampling,
   input wire logic conv_active,
   input wire logic dma_req,
   input wire logic watchdog_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ends; ##[1:100] !conv_active; endsequence
   property p_irq_hold; watchdog_irq && !(psel && pwrite) |=> watchdog_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
   property p_irq_cause; $rose(watchdog_irq) |-> $past(conv_active) ||
      $past(conv_active, 2) || $past(psel); endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq");
   property p_dma_pulse; dma_req |=> !dma_req; endproperty
   a_dma_pulse: assert property (p_dma_pulse) else $error("dma");
   property p_dma_after; dma_req |-> $past(conv_active) ||
      $past(conv_active, 2) || $past(conv_active, 3); endproperty
   a_dma_after: assert property (p_dma_after) else $error("dma");
   property p_samp_in; conv_sampling |-> conv_active; endproperty
   a_samp_in: assert property (p_samp_in) else $error("sample");
   property p_samp_first; $rose(conv_active) |-> conv_sampling; endproperty
   a_samp_first: assert property (p_samp_first) else $error("smp");
   property p_conv_ends; $rose(conv_active) |-> s_ends; endproperty
   a_conv_ends: assert property (p_conv_ends) else $error("long");
   property p_chan; conv_active && $past(conv_active) |-> $stable(conv_channel);
   endproperty
   a_chan: assert property (p_chan) else $error("channel");
endmodule : asw_top_props
bind asw_top asw_top_props u_props (.pclk, .presetn, .psel, .pwrite,
   .conv_channel, .conv_sampling, .conv_active, .dma_req, .watchdog_irq);

// ===== test/tb_top.sv
// Self-checking bench of the converter sequencer over APB.
// Assumes the core model answers each conversion from its channel.
module tb_top
   import asw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, itrig = 0, rtrig = 0, dma_req, watchdog_irq;
   logic act_q = 0;
   logic [11:0] core_result;
   logic [4:0] conv_channel, chq[$];
   logic conv_sampling, conv_active;
   int num_errors = 0, checked = 0, ndma = 0;
   initial forever #2 pclk = ~pclk;
   asw_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .regular_trigger(rtrig),
      .injected_trigger(itrig), .core_result, .conv_channel,
      .conv_sampling, .conv_active, .dma_req, .watchdog_irq);
   asw_core_model CORE (.pclk, .conv_channel, .conv_active, .core_result);
   always @(negedge pclk) begin
      if (dma_req === 1'b1) ndma++;
      if (conv_active === 1'b1 && !act_q) chq.push_back(conv_channel);
      act_q = (conv_active === 1'b1);
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e,
      input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd & m);
   endtask : rdchk
   task automatic wait_idle;
      int quiet = 0;
      repeat (200) begin
         apb(1'b0, OFS_STATUS, 32'h0);
         quiet = (rd[SR_BUSY] === 1'b0) ? quiet + 1 : 0;
         if (quiet == 2) return;
      end
      chk("idle", 32'h0, 32'h1);
   endtask : wait_idle
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(OFS_HTR, 32'hFFFF, 32'h0FFF, "high");
      rdchk(OFS_LTR, 32'hFFFF, 32'h0000, "low");
      apb(1'b1, OFS_HTR, 32'hF200);
      apb(1'b1, OFS_LTR, 32'h0100);
      apb(1'b1, OFS_SEQ0, 32'h0020_0000);
      apb(1'b1, OFS_SEQ0 + 8'h08, 32'h0000_0C41);
      apb(1'b1, OFS_JSEQ, 32'h0000_0005);
      apb(1'b1, OFS_JOFF0, 32'h0000_0100);
      apb(1'b1, OFS_CTRL1, 32'h0080_0140);
      apb(1'b1, OFS_CTRL2, 32'h0000_0501);
      apb(1'b1, OFS_CTRL2, 32'h4000_0501);
      wait_idle;
      for (int i = 0; i < 3; i++) chk("chan", i + 1, chq[i]);
      rdchk(OFS_DR, 32'hFFFF, 32'h0350, "regular");
      rdchk(OFS_STATUS, 32'h7, 32'h3, "status");
      chk("irq", 32'h1, {31'h0, watchdog_irq});
      apb(1'b1, OFS_STATUS, 32'h0);
      rdchk(OFS_STATUS, 32'h7, 32'h0, "cleared");
      $display("test scan done");
      itrig <= 1'b1;
      repeat (8) @(posedge pclk);
      itrig <= 1'b0;
      wait_idle;
      rdchk(OFS_JRES0, 32'hFFFF, 32'h0450, "injected");
      rdchk(OFS_STATUS, 32'h7, 32'h4, "unguarded");
      chk("dma", 32'h3, ndma);
      apb(1'b0, 8'h60, 32'h0);
      chk("slverr", 32'h1, {31'h0, serr});
      $display("test injected done");
      apb(1'b1, OFS_CTRL1, 32'h0000_0500);
      rtrig <= 1'b1;
      repeat (8) @(posedge pclk);
      rtrig <= 1'b0;
      wait_idle;
      chk("auto", 32'h5, chq[7]);
      $display("test auto done");
      tally_and_finish;
   end
endmodule : tb_top
